/* nv_option_load_and_security_key.sv */
// Loads protection and option bytes at reset and runs the security key.
// Assumes an AXI4-Lite master on aclk and nonvolatile bytes on aclk.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module nv_option_load_and_security_key (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [nv_option_pkg::ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [nv_option_pkg::DATA_WIDTH-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [nv_option_pkg::ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [nv_option_pkg::DATA_WIDTH-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [63:0] backdoor_comparison_key,
  input wire logic [7:0] stored_protection_byte,
  input wire logic [7:0] stored_option_byte,
  input wire logic code_from_secure,
  input wire logic background_debug_mode,
  input wire logic mass_erase_done,
  input wire logic blank_check_pass,
  output logic security_engaged,
  output logic ram_access_allow,
  output logic [7:0] protection_out,
  output logic vector_redirect_disable,
  output logic eeprom_page_mode,
  output logic eeprom_page_select,
  output logic load_done
);
  import nv_option_pkg::*;

  key_state_type key_state;
  logic load_pending;
  logic [7:0] flash_protection_working;
  logic [7:0] option_loaded;
  logic secured;
  logic erase_seen;
  logic page_select;
  logic config_reserved;

  logic aw_held;
  logic w_held;
  logic [INDEX_WIDTH-1:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic trusted_source;
  logic write_hit;
  logic [INDEX_WIDTH-1:0] ar_index;
  logic [DATA_WIDTH-1:0] next_rdata;
  logic read_hit;

  logic [7:0] entered [KEY_BYTES];
  logic [KEY_BYTES-1:0] entered_mask;
  logic [KEY_BYTES-1:0] byte_match;
  logic key_enabled;
  logic key_write;
  logic key_close;
  logic key_open;
  logic [2:0] key_slot;
  logic [INDEX_WIDTH-1:0] key_offset;

  logic [7:0] option_view;
  logic [7:0] config_view;
  logic [7:0] status_view;

  // Write channel capture, either order
  assign awready = !aw_held;
  assign wready = !w_held;
  assign do_write = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_index <= awaddr[ADDR_WIDTH-1:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_byte <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    write_hit = (aw_index == IDX_OPTION_WORKING) ||
                (aw_index == IDX_CONFIGURATION) ||
                (aw_index == IDX_PROTECTION_WORKING) ||
                (aw_index == IDX_SECURITY_STATUS) ||
                (aw_index == IDX_STORED_PROTECTION) ||
                (aw_index == IDX_STORED_OPTION) ||
                (aw_index >= IDX_KEY_FIRST && aw_index <= IDX_KEY_LAST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Reset load of working copies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_loaded <= OPTION_RESET;
    end else if (load_pending) begin
      option_loaded <= stored_option_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_protection_working <= PROTECTION_RESET;
    end else if (load_pending) begin
      flash_protection_working <= stored_protection_byte;
    end else if (do_write && w_lane0 &&
                 aw_index == IDX_PROTECTION_WORKING) begin
      flash_protection_working <= w_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_select <= 1'b0;
      config_reserved <= CONFIG_RESERVED_RESET[CONFIG_RESERVED_POS];
    end else if (do_write && w_lane0 &&
                 aw_index == IDX_CONFIGURATION) begin
      page_select <= w_byte[PAGE_SELECT_POS];
      config_reserved <= w_byte[CONFIG_RESERVED_POS];
    end
  end

  // Key path
  assign key_enabled = option_loaded[KEY_ENABLE_POS];
  assign trusted_source = code_from_secure &&
                          !background_debug_mode;
  assign key_offset = aw_index - IDX_KEY_FIRST;
  assign key_slot = key_offset[2:0];
  assign key_open = do_write && w_lane0 &&
                    aw_index == IDX_CONFIGURATION &&
                    w_byte[KEY_ACCESS_POS] && key_enabled &&
                    secured && trusted_source;
  assign key_close = do_write && w_lane0 &&
                     aw_index == IDX_CONFIGURATION &&
                     !w_byte[KEY_ACCESS_POS];
  assign key_write = do_write && w_lane0 && key_state == KEY_ENTRY &&
                     trusted_source &&
                     aw_index >= IDX_KEY_FIRST &&
                     aw_index <= IDX_KEY_LAST;

  generate
    for (genvar i = 0; i < KEY_BYTES; i++) begin : g_key
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          entered[i] <= 8'h00;
          entered_mask[i] <= 1'b0;
        end else if (key_open) begin
          entered_mask[i] <= 1'b0;
        end else if (key_write && key_slot == i) begin
          entered[i] <= w_byte;
          entered_mask[i] <= 1'b1;
        end
      end
      assign byte_match[i] = entered_mask[i] &&
        (entered[i] == backdoor_comparison_key[8*i +: 8]);
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_state <= KEY_IDLE;
    end else begin
      unique case (key_state)
        KEY_IDLE: begin
          if (key_open) begin
            key_state <= KEY_ENTRY;
          end
        end
        KEY_ENTRY: begin
          if (key_close) begin
            key_state <= (&byte_match && key_enabled) ?
                         KEY_DONE : KEY_LOCKED;
          end
        end
        KEY_DONE: begin
          key_state <= KEY_DONE;
        end
        KEY_LOCKED: begin
          key_state <= KEY_LOCKED;
        end
      endcase
    end
  end

  // Erase then blank check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_seen <= 1'b0;
    end else if (mass_erase_done) begin
      erase_seen <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secured <= 1'b1;
    end else if (load_pending) begin
      secured <= stored_option_byte[SECURITY_LSB +: 2] !=
                 SECURITY_UNSECURED;
    end else if (key_state == KEY_ENTRY && key_close &&
                 &byte_match && key_enabled) begin
      secured <= 1'b0;
    end else if (erase_seen && blank_check_pass) begin
      secured <= 1'b0;
    end
  end

  // Register views
  always_comb begin
    option_view = 8'h00;
    option_view[KEY_ENABLE_POS] = option_loaded[KEY_ENABLE_POS];
    option_view[REDIRECT_DISABLE_POS] =
      option_loaded[REDIRECT_DISABLE_POS];
    option_view[PAGE_MODE_POS] = option_loaded[PAGE_MODE_POS];
    option_view[SECURITY_LSB +: 2] =
      option_loaded[SECURITY_LSB +: 2];
  end

  always_comb begin
    config_view = 8'h00;
    config_view[PAGE_SELECT_POS] = page_select;
    config_view[KEY_ACCESS_POS] = (key_state == KEY_ENTRY);
    config_view[CONFIG_RESERVED_POS] = config_reserved;
  end

  always_comb begin
    status_view = 8'h00;
    status_view[STAT_SECURED_POS] = secured;
    status_view[STAT_LOCKED_POS] = (key_state == KEY_LOCKED);
    status_view[STAT_ERASED_POS] = erase_seen;
    status_view[STAT_LOADED_POS] = !load_pending;
  end

  // Read channel
  assign arready = !rvalid;
  assign ar_index = araddr[ADDR_WIDTH-1:2];

  always_comb begin
    next_rdata = '0;
    read_hit = 1'b1;
    if (ar_index == IDX_OPTION_WORKING) begin
      next_rdata[7:0] = option_view;
    end else if (ar_index == IDX_CONFIGURATION) begin
      next_rdata[7:0] = config_view;
    end else if (ar_index == IDX_PROTECTION_WORKING) begin
      next_rdata[7:0] = flash_protection_working;
    end else if (ar_index == IDX_SECURITY_STATUS) begin
      next_rdata[7:0] = status_view;
    end else if (ar_index == IDX_STORED_PROTECTION) begin
      next_rdata[7:0] = stored_protection_byte;
    end else if (ar_index == IDX_STORED_OPTION) begin
      next_rdata[7:0] = stored_option_byte;
    end else if (ar_index >= IDX_KEY_FIRST &&
                 ar_index <= IDX_KEY_LAST) begin
      next_rdata[7:0] =
        backdoor_comparison_key[8*ar_index[2:0] +: 8];
    end else begin
      read_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Outputs
  assign security_engaged = secured;
  assign ram_access_allow = !secured || trusted_source;
  assign protection_out = flash_protection_working;
  assign vector_redirect_disable = option_loaded[REDIRECT_DISABLE_POS];
  assign eeprom_page_mode = option_loaded[PAGE_MODE_POS];
  assign eeprom_page_select = page_select;
  assign load_done = !load_pending;

endmodule : nv_option_load_and_security_key

`default_nettype wire

/* nv_option_load_and_security_key_properties.sv */
// Concurrent checks on the option load and security key block ports.
// Assumes one clock, aclk, and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module nv_option_load_and_security_key_properties
  import nv_option_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic bvalid,
  input wire logic [7:0] stored_protection_byte,
  input wire logic [7:0] stored_option_byte,
  input wire logic code_from_secure,
  input wire logic background_debug_mode,
  input wire logic blank_check_pass,
  input wire logic security_engaged,
  input wire logic ram_access_allow,
  input wire logic [7:0] protection_out,
  input wire logic vector_redirect_disable,
  input wire logic eeprom_page_mode,
  input wire logic load_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_load;
    !load_done ##1 load_done;
  endsequence
  sequence s_unlock_cause;
    $rose(load_done) or $rose(bvalid) or $past(blank_check_pass);
  endsequence

  property p_load_once;
    $rose(aresetn) |-> s_load;
  endproperty
  a_load_once: assert property (p_load_once)
    else $error("load cycle missing after reset");
  property p_load_prot;
    $rose(load_done) |-> protection_out == stored_protection_byte;
  endproperty
  a_load_prot: assert property (p_load_prot)
    else $error("protection byte not loaded");
  property p_load_sec;
    $rose(load_done) |->
      security_engaged == (stored_option_byte[1:0] != SECURITY_UNSECURED);
  endproperty
  a_load_sec: assert property (p_load_sec)
    else $error("security state wrong after load");
  property p_load_opt;
    $rose(load_done) |-> vector_redirect_disable == stored_option_byte[6]
      && eeprom_page_mode == stored_option_byte[5];
  endproperty
  a_load_opt: assert property (p_load_opt)
    else $error("option bits wrong after load");
  property p_ram;
    ram_access_allow ==
      (!security_engaged || (code_from_secure && !background_debug_mode));
  endproperty
  a_ram: assert property (p_ram)
    else $error("ram access gate wrong");
  property p_fell_cause;
    $fell(security_engaged) |-> s_unlock_cause;
  endproperty
  a_fell_cause: assert property (p_fell_cause)
    else $error("security lifted without cause");
  property p_no_rise;
    $past(load_done) |-> !$rose(security_engaged);
  endproperty
  a_no_rise: assert property (p_no_rise)
    else $error("security engaged again without reset");
  property p_key_en;
    $fell(security_engaged) && $rose(bvalid) |-> stored_option_byte[7];
  endproperty
  a_key_en: assert property (p_key_en)
    else $error("key unlocked with key disabled");
  property p_read;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_read: assert property (p_read)
    else $error("read answer late");
endmodule : nv_option_load_and_security_key_properties
`default_nettype wire

/* nv_option_load_and_security_key_test.sv */
// Self-checking bench for the option load and security key block.
// Assumes the block's package and the properties checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module nv_option_load_and_security_key_test;
  import nv_option_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic bready = 1'h1, rready = 1'h1;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h1;
  logic [63:0] backdoor_comparison_key = 64'h0123456789ABCDEF;
  logic [7:0] stored_protection_byte = 8'h5A, stored_option_byte = 8'hFD;
  logic code_from_secure = 1'h1, background_debug_mode = 1'h0;
  logic mass_erase_done = 1'h0, blank_check_pass = 1'h0;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, security_engaged;
  logic ram_access_allow, vector_redirect_disable, eeprom_page_mode;
  logic eeprom_page_select, load_done;
  logic [7:0] protection_out;
  int error_cnt = 0, checks_done = 0;

  nv_option_load_and_security_key i_dut (.*);
  always #2 aclk = ~aclk;

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic a, w, b;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(negedge aclk);
      a = awvalid && awready === 1'h1;
      w = wvalid && wready === 1'h1;
      b = bvalid === 1'h1;
      resp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end while (!b);
  endtask : wr
  task automatic rdr(input logic [15:0] idx);
    logic a, r;
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    do begin
      @(negedge aclk);
      a = arvalid && arready === 1'h1;
      r = rvalid === 1'h1;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'h0;
    end while (!r);
  endtask : rdr
  task automatic do_reset(input logic [7:0] opt);
    aresetn <= 1'h0;
    stored_option_byte <= opt;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
  endtask : do_reset
  task automatic key_try(input logic [63:0] k);
    wr(IDX_CONFIGURATION, 8'h30);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_KEY_FIRST + 16'(i), k[8*i +: 8]);
    end
    wr(IDX_CONFIGURATION, 8'h10);
  endtask : key_try
  task automatic sec_chk(input logic e);
    chk("secured", {31'h0, e}, {31'h0, security_engaged});
    rdr(IDX_SECURITY_STATUS);
    chk("status_secured", {31'h0, e}, {31'h0, rd[STAT_SECURED_POS]});
  endtask : sec_chk
  task automatic pulse(input logic erase);
    if (erase) mass_erase_done <= 1'h1;
    else blank_check_pass <= 1'h1;
    @(posedge aclk);
    mass_erase_done <= 1'h0;
    blank_check_pass <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask : pulse

  task automatic t_load;
    do_reset(8'hFD);
    chk("prot", 32'h5A, {24'h0, protection_out});
    rdr(IDX_OPTION_WORKING);
    chk("option", 32'hE1, rd);
    chk("opt_bits", 32'h3, {30'h0, vector_redirect_disable,
      eeprom_page_mode});
    sec_chk(1'h1);
    chk("status", 32'h9, rd);
    chk("ram", 32'h1, {31'h0, ram_access_allow});
    rdr(IDX_STORED_OPTION);
    chk("stored_opt", 32'hFD, rd);
    rdr(IDX_KEY_FIRST);
    chk("key0", 32'hEF, rd);
    rdr(16'h0000);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(IDX_PROTECTION_WORKING, 8'h33);
    chk("prot_wr", 32'h33, {24'h0, protection_out});
    chk("wr_okay", {30'h0, RESP_OKAY}, {30'h0, resp});
    wstrb <= 4'h0;
    wr(IDX_PROTECTION_WORKING, 8'h44);
    chk("prot_nostrb", 32'h33, {24'h0, protection_out});
    wstrb <= 4'h1;
    wr(IDX_CONFIGURATION, 8'h50);
    chk("page_sel", 32'h1, {31'h0, eeprom_page_select});
    rdr(IDX_CONFIGURATION);
    chk("config", 32'h50, rd);
    wr(16'h0000, 8'h00);
    chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
  endtask : t_load
  task automatic t_untrusted;
    background_debug_mode <= 1'h1;
    @(posedge aclk);
    chk("ram_dbg", 32'h0, {31'h0, ram_access_allow});
    key_try(backdoor_comparison_key);
    sec_chk(1'h1);
    background_debug_mode <= 1'h0;
    code_from_secure <= 1'h0;
    key_try(backdoor_comparison_key);
    sec_chk(1'h1);
    code_from_secure <= 1'h1;
    key_try(backdoor_comparison_key ^ 64'h0100000000000000);
    sec_chk(1'h1);
    chk("locked", 32'h1, {31'h0, rd[STAT_LOCKED_POS]});
    key_try(backdoor_comparison_key);
    sec_chk(1'h1);
  endtask : t_untrusted
  task automatic t_good;
    do_reset(8'hFD);
    chk("prot_reload", 32'h5A, {24'h0, protection_out});
    key_try(backdoor_comparison_key);
    sec_chk(1'h0);
  endtask : t_good
  task automatic t_disabled;
    do_reset(8'h7D);
    key_try(backdoor_comparison_key);
    sec_chk(1'h1);
    pulse(1'h0);
    sec_chk(1'h1);
    pulse(1'h1);
    pulse(1'h0);
    sec_chk(1'h0);
  endtask : t_disabled
  task automatic t_sec_codes;
    for (int s = 0; s < 4; s++) begin
      do_reset({6'h20, 2'(s)});
      sec_chk(s != 2);
    end
  endtask : t_sec_codes

  task summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    t_load();
    t_untrusted();
    t_good();
    t_disabled();
    t_sec_codes();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
endmodule : nv_option_load_and_security_key_test

bind nv_option_load_and_security_key
  nv_option_load_and_security_key_properties i_props (.*);
`default_nettype wire

/* nv_option_pkg.sv */
// Constants for the nonvolatile option load and security key block.
// Assumes a word-indexed register map: byte address = 4 * index.
package nv_option_pkg;

  localparam int unsigned ADDR_WIDTH = 18;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned INDEX_WIDTH = 16;
  localparam int unsigned KEY_BYTES = 8;

  // Register indices
  localparam logic [15:0] IDX_OPTION_WORKING = 16'h1821;
  localparam logic [15:0] IDX_CONFIGURATION = 16'h1823;
  localparam logic [15:0] IDX_PROTECTION_WORKING = 16'h1824;
  localparam logic [15:0] IDX_SECURITY_STATUS = 16'h1827;
  localparam logic [15:0] IDX_KEY_FIRST = 16'hFFB0;
  localparam logic [15:0] IDX_KEY_LAST = 16'hFFB7;
  localparam logic [15:0] IDX_STORED_PROTECTION = 16'hFFBD;
  localparam logic [15:0] IDX_STORED_OPTION = 16'hFFBF;

  // Option byte fields
  localparam int unsigned KEY_ENABLE_POS = 7;
  localparam int unsigned REDIRECT_DISABLE_POS = 6;
  localparam int unsigned PAGE_MODE_POS = 5;
  localparam int unsigned SECURITY_LSB = 0;
  localparam logic [1:0] SECURITY_UNSECURED = 2'h2;

  // Configuration byte fields
  localparam int unsigned PAGE_SELECT_POS = 6;
  localparam int unsigned KEY_ACCESS_POS = 5;
  localparam int unsigned CONFIG_RESERVED_POS = 4;

  // Security status fields
  localparam int unsigned STAT_SECURED_POS = 0;
  localparam int unsigned STAT_LOCKED_POS = 1;
  localparam int unsigned STAT_ERASED_POS = 2;
  localparam int unsigned STAT_LOADED_POS = 3;

  // Values after reset
  localparam logic [7:0] PROTECTION_RESET = 8'hFF;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESERVED_RESET = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'h0,
    KEY_ENTRY = 2'h1,
    KEY_DONE = 2'h3,
    KEY_LOCKED = 2'h2
  } key_state_type;

endpackage : nv_option_pkg
